// file: bdh_pkg.sv
`default_nettype none
package bdh_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int BIT_PERIOD_NS = 80;
	localparam int SETTLE_NS     = 16;
	// Least times, rounded up to whole cycles
	localparam int BIT_CYC    = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Field layout and counter states
	// ----------------------------------------
	localparam int         BYTE_BITS   = 8;
	localparam int         SEL_BITS    = 3;
	localparam int         DEST_BITS   = 4;
	localparam int         DEST_HI_BIT = 3;
	localparam int         LINES       = 8;
	localparam logic [2:0] CNT_ZERO    = 3'h0;
	localparam logic [2:0] CNT_SKIP    = 3'h4;
	localparam logic [2:0] CNT_FIFTH   = 3'h7;
	localparam logic [2:0] BIT_LAST    = 3'h7;

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_COUNT
	} bdh_state_type;
endpackage : bdh_pkg
`default_nettype wire

// file: bdh_host.sv
`default_nettype none
module bdh_host #(
	parameter int BIT_CYC    = bdh_pkg::BIT_CYC,
	parameter int SETTLE_CYC = bdh_pkg::SETTLE_CYC
) (
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RST_IN,
	input  wire logic        XFER_START_IN,
	input  wire logic [7:0]  XFER_DATA_IN,
	input  wire logic [3:0]  XFER_DEST_IN,
	input  wire logic        XFER_SPREAD_IN,
	output logic             XFER_BUSY_OUT,
	output logic             XFER_DONE_OUT,
	input  wire logic        CNT_MODE_IN,
	input  wire logic        CNT_STEP_IN,
	output logic [2:0]       CNT_STATE_OUT,
	output logic             CNT_WRAP_OUT,
	output logic [2:0]       SEL_OUT,
	output logic             EN_LO_N_OUT,
	output logic             EN_HI_N_OUT,
	input  wire logic [7:0]  DEC_N_IN,
	output logic [7:0]       DEC_N_OUT
);
	localparam int TW = $clog2(BIT_CYC + 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	bdh_pkg::bdh_state_type state_ff,  nxt_state_ff;
	logic [7:0]             shreg_ff,  nxt_shreg_ff;
	logic [3:0]             dest_ff,   nxt_dest_ff;
	logic                   spread_ff, nxt_spread_ff;
	logic [2:0]             bit_ff,    nxt_bit_ff;
	logic [TW-1:0]          tick_ff,   nxt_tick_ff;
	logic [2:0]             cnt_ff,    nxt_cnt_ff;
	logic [TW-1:0]          settle_ff, nxt_settle_ff;
	logic                   done_ff,   nxt_done_ff;
	logic                   wrap_ff,   nxt_wrap_ff;
	logic [2:0]             sel_ff,    nxt_sel_ff;
	logic                   en_lo_ff,  nxt_en_lo_ff;
	logic                   en_hi_ff,  nxt_en_hi_ff;
	logic [7:0]             dec_s1_ff;
	logic [7:0]             dec_s2_ff;
	logic [3:0]             addr;
	logic                   in_settle;
	logic                   seen_four;

	// Current line address, stepped per bit when spreading
	assign addr      = spread_ff ? 4'(dest_ff + {1'b0, bit_ff}) : dest_ff;
	assign in_settle = spread_ff && (tick_ff < TW'(SETTLE_CYC));
	assign seen_four = !dec_s2_ff[bdh_pkg::CNT_SKIP];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		nxt_state_ff  = state_ff;
		nxt_shreg_ff  = shreg_ff;
		nxt_dest_ff   = dest_ff;
		nxt_spread_ff = spread_ff;
		nxt_bit_ff    = bit_ff;
		nxt_tick_ff   = tick_ff;
		nxt_cnt_ff    = cnt_ff;
		nxt_settle_ff = settle_ff;
		nxt_done_ff   = 1'b0;
		nxt_wrap_ff   = 1'b0;
		nxt_sel_ff    = sel_ff;
		nxt_en_lo_ff  = 1'b1;
		nxt_en_hi_ff  = 1'b1;
		case (state_ff)
			bdh_pkg::ST_IDLE: begin
				if (XFER_START_IN) begin
					nxt_state_ff  = bdh_pkg::ST_SHIFT;
					nxt_shreg_ff  = XFER_DATA_IN;
					nxt_dest_ff   = XFER_DEST_IN;
					nxt_spread_ff = XFER_SPREAD_IN;
					nxt_bit_ff    = 3'h0;
					nxt_tick_ff   = '0;
				end else if (CNT_MODE_IN) begin
					nxt_state_ff  = bdh_pkg::ST_COUNT;
					nxt_cnt_ff    = bdh_pkg::CNT_ZERO;
					nxt_settle_ff = TW'(SETTLE_CYC);
				end
			end
			bdh_pkg::ST_SHIFT: begin
				// Data rides the enable of the decoder picked by the high bit
				nxt_sel_ff = addr[2:0];
				if (!in_settle) begin
					if (addr[bdh_pkg::DEST_HI_BIT]) begin
						nxt_en_hi_ff = shreg_ff[0];
					end else begin
						nxt_en_lo_ff = shreg_ff[0];
					end
				end
				if (tick_ff == TW'(BIT_CYC - 1)) begin
					nxt_tick_ff  = '0;
					nxt_shreg_ff = {1'b1, shreg_ff[7:1]};
					nxt_bit_ff   = 3'(bit_ff + 3'h1);
					if (bit_ff == bdh_pkg::BIT_LAST) begin
						nxt_state_ff = bdh_pkg::ST_IDLE;
						nxt_done_ff  = 1'b1;
					end
				end else begin
					nxt_tick_ff = TW'(tick_ff + 1'b1);
				end
			end
			bdh_pkg::ST_COUNT: begin
				nxt_sel_ff   = cnt_ff;
				nxt_en_lo_ff = (settle_ff != '0);
				if (settle_ff != '0) begin
					nxt_settle_ff = TW'(settle_ff - 1'b1);
				end
				if (!CNT_MODE_IN) begin
					nxt_state_ff = bdh_pkg::ST_IDLE;
				end else if (cnt_ff == bdh_pkg::CNT_SKIP) begin
					// Decoded four jumps to seven, the fifth state
					if (settle_ff == '0 && seen_four) begin
						nxt_cnt_ff    = bdh_pkg::CNT_FIFTH;
						nxt_settle_ff = TW'(SETTLE_CYC);
					end
				end else if (CNT_STEP_IN) begin
					nxt_cnt_ff    = 3'(cnt_ff + 3'h1);
					nxt_settle_ff = TW'(SETTLE_CYC);
					nxt_wrap_ff   = (cnt_ff == bdh_pkg::CNT_FIFTH);
				end
			end
			default: begin
				nxt_state_ff = bdh_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			state_ff  <= bdh_pkg::ST_IDLE;
			shreg_ff  <= 8'hff;
			dest_ff   <= 4'h0;
			spread_ff <= 1'b0;
			bit_ff    <= 3'h0;
			tick_ff   <= '0;
			cnt_ff    <= bdh_pkg::CNT_ZERO;
			settle_ff <= '0;
			done_ff   <= 1'b0;
			wrap_ff   <= 1'b0;
			sel_ff    <= 3'h0;
			en_lo_ff  <= 1'b1;
			en_hi_ff  <= 1'b1;
			dec_s1_ff <= 8'hff;
			dec_s2_ff <= 8'hff;
		end else begin
			state_ff  <= nxt_state_ff;
			shreg_ff  <= nxt_shreg_ff;
			dest_ff   <= nxt_dest_ff;
			spread_ff <= nxt_spread_ff;
			bit_ff    <= nxt_bit_ff;
			tick_ff   <= nxt_tick_ff;
			cnt_ff    <= nxt_cnt_ff;
			settle_ff <= nxt_settle_ff;
			done_ff   <= nxt_done_ff;
			wrap_ff   <= nxt_wrap_ff;
			sel_ff    <= nxt_sel_ff;
			en_lo_ff  <= nxt_en_lo_ff;
			en_hi_ff  <= nxt_en_hi_ff;
			dec_s1_ff <= DEC_N_IN;   // Pin synchroniser, first stage
			dec_s2_ff <= dec_s1_ff;
		end
	end

	// Outputs
	assign XFER_BUSY_OUT = (state_ff == bdh_pkg::ST_SHIFT);
	assign XFER_DONE_OUT = done_ff;
	assign CNT_STATE_OUT = cnt_ff;
	assign CNT_WRAP_OUT  = wrap_ff;
	assign SEL_OUT       = sel_ff;
	assign EN_LO_N_OUT   = en_lo_ff;
	assign EN_HI_N_OUT   = en_hi_ff;
	assign DEC_N_OUT     = dec_s2_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_idle_enables_off: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_IDLE |=> en_lo_ff && en_hi_ff)
		else $error("enable driven while idle");
	chk_one_decoder_on: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		en_lo_ff || en_hi_ff)
		else $error("both decoders enabled");
	chk_upper_half_off: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_SHIFT && !addr[3] |=> en_hi_ff)
		else $error("upper decoder enabled for low address");
	chk_sel_from_addr: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_SHIFT |=> sel_ff == $past(addr[2:0]))
		else $error("select does not follow address");
	chk_fixed_dest_sel: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_SHIFT && !spread_ff && $past(state_ff) == bdh_pkg::ST_SHIFT
		|=> $stable(sel_ff))
		else $error("select moved during fixed transfer");
	chk_bit_step_rate: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_SHIFT && tick_ff == TW'(BIT_CYC - 1)
		|=> bit_ff == 3'($past(bit_ff) + 3'h1))
		else $error("bit index not stepped at bit end");
	chk_force_seven: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_COUNT && CNT_MODE_IN && cnt_ff == bdh_pkg::CNT_SKIP
		&& settle_ff == '0 && seen_four |=> cnt_ff == bdh_pkg::CNT_FIFTH)
		else $error("decoded four did not force seven");
	chk_wrap_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_COUNT && CNT_MODE_IN && cnt_ff == bdh_pkg::CNT_FIFTH
		&& CNT_STEP_IN |=> cnt_ff == bdh_pkg::CNT_ZERO && wrap_ff)
		else $error("seven did not wrap to zero");
	chk_settle_inhibit: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		state_ff == bdh_pkg::ST_COUNT && $changed(sel_ff) |-> en_lo_ff && en_hi_ff)
		else $error("enable low while counter settles");
endmodule : bdh_host
`default_nettype wire

// file: bdh_dec.sv
`default_nettype none
// Behavioural 1-of-8 decoder with active-low lines and enable
module bdh_dec (
	input  wire logic [2:0] sel_in,
	input  wire logic       en_n_in,
	output logic      [7:0] dec_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Only the addressed line drops, and only while enabled
	always_comb begin
		dec_n_out = 8'hff;
		if (en_n_in === 1'b0) begin
			dec_n_out[sel_in] = 1'b0;
		end
	end
endmodule : bdh_dec
`default_nettype wire

// file: bdh_host_tb.sv
`default_nettype none
module bdh_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BC = 4;
	logic       clk = 1'b0, rst = 1'b1, start = 1'b0, spread = 1'b0;
	logic       mode = 1'b0, step = 1'b0;
	logic [7:0] data = 8'h00;
	logic [3:0] dest = 4'h0;
	logic       busy, done, wrap, en_lo_n, en_hi_n;
	logic [2:0] cnt, sel;
	logic [7:0] dec_lo, dec_hi, dec_sync;
	int         error_cnt = 0, cmp_count = 0, cyc = 0;

	// Clock and cycle ceiling
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end

	bdh_host #(.BIT_CYC(BC), .SETTLE_CYC(1)) u_dut (
		.CLK_SYS_IN     (clk),
		.RST_IN         (rst),
		.XFER_START_IN  (start),
		.XFER_DATA_IN   (data),
		.XFER_DEST_IN   (dest),
		.XFER_SPREAD_IN (spread),
		.XFER_BUSY_OUT  (busy),
		.XFER_DONE_OUT  (done),
		.CNT_MODE_IN    (mode),
		.CNT_STEP_IN    (step),
		.CNT_STATE_OUT  (cnt),
		.CNT_WRAP_OUT   (wrap),
		.SEL_OUT        (sel),
		.EN_LO_N_OUT    (en_lo_n),
		.EN_HI_N_OUT    (en_hi_n),
		.DEC_N_IN       (dec_lo),
		.DEC_N_OUT      (dec_sync)
	);
	// Two decoders share select; one per enable
	bdh_dec u_dec_lo (.sel_in(sel), .en_n_in(en_lo_n), .dec_n_out(dec_lo));
	bdh_dec u_dec_hi (.sel_in(sel), .en_n_in(en_hi_n), .dec_n_out(dec_hi));

	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Idle levels after reset
	task automatic test_reset;
		chk({5'h00, en_hi_n, en_lo_n, busy, done, wrap, cnt, sel}, 16'h0600);
		chk({8'h00, dec_sync}, 16'h00ff);
		$display("reset test done");
	endtask : test_reset

	// One byte over the 16-line decoder pair, checked at each bit end
	task automatic test_xfer(input logic [7:0] d, input logic [3:0] a, input logic sp);
		logic [3:0]  ln;
		logic [15:0] exp;
		data = d;
		dest = a;
		spread = sp;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		// Sample each bit in its last cycle, clear of the settle gap
		for (int i = 0; i < 8; i++) begin
			repeat (BC) @(negedge clk);
			ln = a + (sp ? i[3:0] : 4'h0);
			exp = 16'hffff;
			exp[ln] = d[i];
			chk({dec_hi, dec_lo}, exp);
		end
		chk({14'h0000, done, busy}, 16'h0002);
		@(negedge clk);
		chk({dec_hi, dec_lo}, 16'hffff);
		$display("transfer test done");
	endtask : test_xfer

	// Divide-by-five sequence through the decoder
	task automatic test_count;
		logic [2:0] seq [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
		mode = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 4; i++) begin
			step = 1'b1;
			@(negedge clk);
			step = 1'b0;
			chk({13'h0000, cnt}, {13'h0000, seq[i]});
			repeat (2) @(negedge clk);
		end
		step = 1'b1;
		@(negedge clk);
		step = 1'b0;
		for (int k = 0; k < 20 && cnt === 3'h4; k++) @(negedge clk);
		chk({13'h0000, cnt}, 16'h0007);
		repeat (4) @(negedge clk);
		chk({dec_sync, dec_lo}, 16'h7f7f);
		step = 1'b1;
		@(negedge clk);
		step = 1'b0;
		chk({12'h000, wrap, cnt}, 16'h0008);
		mode = 1'b0;
		repeat (3) @(negedge clk);
		$display("counter test done");
	endtask : test_count

	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		test_reset();
		test_xfer(8'ha5, 4'hd, 1'b0);
		@(negedge clk);
		test_xfer(8'h3c, 4'h6, 1'b1);
		@(negedge clk);
		test_count();
		final_report();
	end
endmodule : bdh_host_tb
`default_nettype wire
